// [common/rcmbd_pkg.sv]
// Contract
// - Command select low means command mode
// - Command mode bytes go to interpreter only
// - Select low at power-up restores factory defaults
// - Mode and power apply only at diagnostic start
// - Receive diagnostic ignores the power setting
// - Transmit diagnostic sends alternating one-zero pattern
// - Receive diagnostic enables receiver, enters error test
// - Error test reports error count and percentage
// - Receive test may wait until power cycle
// - Volatile settings are lost at power loss
// - Power-on loads working set from defaults
`default_nettype none
package rcmbd_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         BIT_PERIOD_NS = 1000;
   localparam int         BIT_DIV       = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] BIT_DIV_LAST  = 7'(BIT_DIV - 1);
   localparam logic [1:0] PWR_SETTLE    = 2'h3;
   localparam int         BER_LEN       = 1000;
   localparam logic [9:0] BER_LAST      = 10'(BER_LEN - 1);
   localparam int         BER_PCT_STEP  = BER_LEN / 100;
   localparam logic [3:0] PCT_STEP_LAST = 4'(BER_PCT_STEP - 1);

   // ---------------------------------------------------------------
   // Register map and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CHAN   = 8'h00;
   localparam logic [7:0] REG_XMODE  = 8'h04;
   localparam logic [7:0] REG_DIAG   = 8'h08;
   localparam logic [7:0] REG_BERR   = 8'h0C;
   localparam logic [7:0] REG_BPCT   = 8'h10;
   localparam logic [7:0] REG_STAT   = 8'h14;
   localparam int         DIAG_TX    = 0;
   localparam int         DIAG_RX    = 1;
   localparam int         DIAG_STOP  = 2;
   localparam int         XM_MOD_LSB = 0;
   localparam int         XM_PWR_LSB = 2;
   localparam int         BPCT_DONE  = 8;
   localparam int         NV_W       = 12;
   localparam int         NV_XM_LSB  = 8;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLV   = 2'h2;

   // ---------------------------------------------------------------
   // Reset and factory values
   // ---------------------------------------------------------------
   localparam logic [7:0] VOL_RST_CHAN  = 8'h00;
   localparam logic [3:0] VOL_RST_XMODE = 4'h0;
   localparam logic [7:0] FACT_CHAN     = 8'h00;
   localparam logic [3:0] FACT_XMODE    = 4'h0;

   typedef enum logic [2:0] {
      ST_INIT, ST_IDLE, ST_TXD, ST_RXW, ST_RXC, ST_RXDONE
   } rcmbd_state_t;
endpackage : rcmbd_pkg
`default_nettype wire

// [design/rcmbd_sync.sv]
`default_nettype none
module rcmbd_sync (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // Asynchronous level in, synchronised level out
   input  wire logic i_d,
   output logic      o_q
);
   logic meta_r;
   logic q_r;

   // Two flops; the first feeds only the second, idle level is high
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_r <= 1'b1;
         q_r    <= 1'b1;
      end else begin
         meta_r <= i_d;
         q_r    <= meta_r;
      end
   end
   assign o_q = q_r;
endmodule // rcmbd_sync
`default_nettype wire

// [design/rcmbd_top.sv]
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
module rcmbd_top import rcmbd_pkg::*; (
   // Clock and reset
   input  wire logic            i_clk,
   input  wire logic            i_rst_n,
   // Command select and UART byte stream
   input  wire logic            i_cmd_n,
   input  wire logic            i_rx_valid,
   input  wire logic [7:0]      i_rx_data,
   input  wire logic            i_rx_busy,
   output logic                 o_cmd_valid,
   output logic [7:0]           o_cmd_data,
   output logic                 o_radio_valid,
   output logic [7:0]           o_radio_data,
   // Non-volatile defaults and factory restore
   input  wire logic [NV_W-1:0] i_nv_cfg,
   output logic                 o_factory_rst,
   // Radio control and data
   output logic                 o_tx_en,
   output logic                 o_tx_bit,
   output logic                 o_rx_en,
   output logic [7:0]           o_chan,
   output logic [1:0]           o_mod,
   output logic [1:0]           o_pwr,
   input  wire logic            i_rf_bit_vld,
   input  wire logic            i_rf_bit,
   // AXI4-Lite slave
   input  wire logic [7:0]      i_s_axi_awaddr,
   input  wire logic            i_s_axi_awvalid,
   output logic                 o_s_axi_awready,
   input  wire logic [31:0]     i_s_axi_wdata,
   input  wire logic [3:0]      i_s_axi_wstrb,
   input  wire logic            i_s_axi_wvalid,
   output logic                 o_s_axi_wready,
   output logic [1:0]           o_s_axi_bresp,
   output logic                 o_s_axi_bvalid,
   input  wire logic            i_s_axi_bready,
   input  wire logic [7:0]      i_s_axi_araddr,
   input  wire logic            i_s_axi_arvalid,
   output logic                 o_s_axi_arready,
   output logic [31:0]          o_s_axi_rdata,
   output logic [1:0]           o_s_axi_rresp,
   output logic                 o_s_axi_rvalid,
   input  wire logic            i_s_axi_rready
);
   // ---------------------------------------------------------------
   // Command select and byte routing
   // ---------------------------------------------------------------
   logic       cmd_sync;
   logic       cmd_mode_r, cmd_mode_nxt;
   logic       cvld_r, cvld_nxt, rvld_r, rvld_nxt;
   logic [7:0] byte_r, byte_nxt;

   rcmbd_sync u_cmd_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_d     (i_cmd_n),
      .o_q     (cmd_sync)
   );

   // Mode only moves between bytes, so a byte never splits paths
   always_comb begin
      cmd_mode_nxt = cmd_mode_r;
      if (!i_rx_busy && !i_rx_valid) begin
         cmd_mode_nxt = !cmd_sync;
      end
      cvld_nxt = i_rx_valid && cmd_mode_r;
      rvld_nxt = i_rx_valid && !cmd_mode_r;
      byte_nxt = i_rx_valid ? i_rx_data : byte_r;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cmd_mode_r <= 1'b0;
         cvld_r     <= 1'b0;
         rvld_r     <= 1'b0;
         byte_r     <= 8'h00;
      end else begin
         cmd_mode_r <= cmd_mode_nxt;
         cvld_r     <= cvld_nxt;
         rvld_r     <= rvld_nxt;
         byte_r     <= byte_nxt;
      end
   end
   assign o_cmd_valid   = cvld_r;
   assign o_cmd_data    = byte_r;
   assign o_radio_valid = rvld_r;
   assign o_radio_data  = byte_r;

   // ---------------------------------------------------------------
   // AXI4-Lite handshakes
   // ---------------------------------------------------------------
   logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic        bvld_r, bvld_nxt, rdv_r, rdv_nxt;
   logic [7:0]  waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, rd_mux;
   logic        wstb0_r, wstb0_nxt, wr_fire, wr_ok, rd_ok;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;

   assign o_s_axi_awready = !aw_got_r && !bvld_r;
   assign o_s_axi_wready  = !w_got_r && !bvld_r;
   assign o_s_axi_arready = !rdv_r;
   assign wr_fire = aw_got_r && w_got_r && !bvld_r;
   assign wr_ok   = ({waddr_r[7:2], 2'b00} == REG_CHAN) || ({waddr_r[7:2], 2'b00} == REG_XMODE)
                 || ({waddr_r[7:2], 2'b00} == REG_DIAG);

   // Address and data are taken in either order; response after both
   always_comb begin
      aw_got_nxt = aw_got_r;
      w_got_nxt  = w_got_r;
      waddr_nxt  = waddr_r;
      wdata_nxt  = wdata_r;
      wstb0_nxt  = wstb0_r;
      bvld_nxt   = bvld_r;
      bresp_nxt  = bresp_r;
      rdv_nxt    = rdv_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (i_s_axi_awvalid && o_s_axi_awready) begin
         aw_got_nxt = 1'b1;
         waddr_nxt  = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
         w_got_nxt = 1'b1;
         wdata_nxt = i_s_axi_wdata;
         wstb0_nxt = i_s_axi_wstrb[0];
      end
      if (wr_fire) begin
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
         bvld_nxt   = 1'b1;
         bresp_nxt  = wr_ok ? RESP_OKAY : RESP_SLV;
      end else if (bvld_r && i_s_axi_bready) begin
         bvld_nxt = 1'b0;
      end
      if (i_s_axi_arvalid && o_s_axi_arready) begin
         rdv_nxt   = 1'b1;
         rdata_nxt = rd_mux;
         rresp_nxt = rd_ok ? RESP_OKAY : RESP_SLV;
      end else if (rdv_r && i_s_axi_rready) begin
         rdv_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         waddr_r  <= 8'h00;
         wdata_r  <= 32'h0000_0000;
         wstb0_r  <= 1'b0;
         bvld_r   <= 1'b0;
         bresp_r  <= RESP_OKAY;
         rdv_r    <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else begin
         aw_got_r <= aw_got_nxt;
         w_got_r  <= w_got_nxt;
         waddr_r  <= waddr_nxt;
         wdata_r  <= wdata_nxt;
         wstb0_r  <= wstb0_nxt;
         bvld_r   <= bvld_nxt;
         bresp_r  <= bresp_nxt;
         rdv_r    <= rdv_nxt;
         rdata_r  <= rdata_nxt;
         rresp_r  <= rresp_nxt;
      end
   end
   assign o_s_axi_bvalid = bvld_r;
   assign o_s_axi_bresp  = bresp_r;
   assign o_s_axi_rvalid = rdv_r;
   assign o_s_axi_rdata  = rdata_r;
   assign o_s_axi_rresp  = rresp_r;

   // ---------------------------------------------------------------
   // Configuration and diagnostic sequencer
   // ---------------------------------------------------------------
   rcmbd_state_t st_r, st_nxt;
   logic [1:0]   settle_r, settle_nxt;
   logic [7:0]   chan_r, chan_nxt, achan_r, achan_nxt;
   logic [3:0]   xm_r, xm_nxt;
   logic [1:0]   amod_r, amod_nxt, apwr_r, apwr_nxt;
   logic         fact_r, fact_nxt, txb_r, txb_nxt, exp_r, exp_nxt, done_r, done_nxt;
   logic [6:0]   div_r, div_nxt;
   logic [9:0]   nbit_r, nbit_nxt, err_r, err_nxt;
   logic [3:0]   sub_r, sub_nxt;
   logic [6:0]   pct_r, pct_nxt;
   logic         tick, wr_lo, tx_go, rx_go, can_go;

   assign tick   = (div_r == BIT_DIV_LAST);
   assign wr_lo  = wr_fire && wstb0_r;
   // The test cannot be aborted once waiting for data; only reset frees it
   assign can_go = (st_r == ST_IDLE) || (st_r == ST_TXD) || (st_r == ST_RXDONE);
   assign tx_go  = wr_lo && can_go && ({waddr_r[7:2], 2'b00} == REG_DIAG) && wdata_r[DIAG_TX];
   assign rx_go  = wr_lo && can_go && ({waddr_r[7:2], 2'b00} == REG_DIAG) && wdata_r[DIAG_RX]
                   && !tx_go;

   always_comb begin
      st_nxt     = st_r;
      settle_nxt = settle_r;
      chan_nxt   = chan_r;
      xm_nxt     = xm_r;
      achan_nxt  = achan_r;
      amod_nxt   = amod_r;
      apwr_nxt   = apwr_r;
      fact_nxt   = 1'b0;
      txb_nxt    = txb_r;
      exp_nxt    = exp_r;
      done_nxt   = done_r;
      nbit_nxt   = nbit_r;
      err_nxt    = err_r;
      sub_nxt    = sub_r;
      pct_nxt    = pct_r;
      div_nxt    = tick ? 7'h00 : div_r + 7'h01;
      // Writes only stage values; the radio sees channel and mode at start, power at transmit start only
      if (wr_lo && ({waddr_r[7:2], 2'b00} == REG_CHAN)) begin
         chan_nxt = wdata_r[7:0];
      end
      if (wr_lo && ({waddr_r[7:2], 2'b00} == REG_XMODE)) begin
         xm_nxt = wdata_r[3:0];
      end
      case (st_r)
         ST_INIT: begin
            settle_nxt = settle_r + 2'h1;
            if (settle_r == PWR_SETTLE) begin
               st_nxt = ST_IDLE;
               if (!cmd_sync) begin
                  fact_nxt = 1'b1;
                  chan_nxt = FACT_CHAN;
                  xm_nxt   = FACT_XMODE;
               end else begin
                  chan_nxt = i_nv_cfg[7:0];
                  xm_nxt   = i_nv_cfg[NV_XM_LSB +: 4];
               end
            end
         end
         ST_TXD: begin
            if (tick) begin
               txb_nxt = !txb_r;
            end
            if (wr_lo && ({waddr_r[7:2], 2'b00} == REG_DIAG) && wdata_r[DIAG_STOP]) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_RXW: begin
            // Locks onto the first one bit; waits without limit otherwise
            if (i_rf_bit_vld && i_rf_bit) begin
               st_nxt  = ST_RXC;
               exp_nxt = 1'b0;
            end
         end
         ST_RXC: begin
            if (i_rf_bit_vld) begin
               exp_nxt  = !exp_r;
               nbit_nxt = nbit_r + 10'h001;
               if (i_rf_bit != exp_r) begin
                  err_nxt = err_r + 10'h001;
                  sub_nxt = (sub_r == PCT_STEP_LAST) ? 4'h0 : sub_r + 4'h1;
                  if (sub_r == PCT_STEP_LAST) begin
                     pct_nxt = pct_r + 7'h01;
                  end
               end
               if (nbit_r == BER_LAST) begin
                  st_nxt   = ST_RXDONE;
                  done_nxt = 1'b1;
               end
            end
         end
         default: begin
         end
      endcase
      if (tx_go) begin
         st_nxt    = ST_TXD;
         achan_nxt = chan_r;
         amod_nxt  = xm_r[XM_MOD_LSB +: 2];
         apwr_nxt  = xm_r[XM_PWR_LSB +: 2];
         txb_nxt   = 1'b1;
      end else if (rx_go) begin
         st_nxt    = ST_RXW;
         achan_nxt = chan_r;
         amod_nxt  = xm_r[XM_MOD_LSB +: 2];
         nbit_nxt  = 10'h000;
         err_nxt   = 10'h000;
         sub_nxt   = 4'h0;
         pct_nxt   = 7'h00;
         done_nxt  = 1'b0;
      end
   end

   // Sync reset clears the working set, as a power loss would
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_r     <= ST_INIT;
         settle_r <= 2'h0;
         chan_r   <= VOL_RST_CHAN;
         xm_r     <= VOL_RST_XMODE;
         achan_r  <= VOL_RST_CHAN;
         amod_r   <= 2'h0;
         apwr_r   <= 2'h0;
         fact_r   <= 1'b0;
         txb_r    <= 1'b0;
         exp_r    <= 1'b0;
         done_r   <= 1'b0;
         div_r    <= 7'h00;
         nbit_r   <= 10'h000;
         err_r    <= 10'h000;
         sub_r    <= 4'h0;
         pct_r    <= 7'h00;
      end else begin
         st_r     <= st_nxt;
         settle_r <= settle_nxt;
         chan_r   <= chan_nxt;
         xm_r     <= xm_nxt;
         achan_r  <= achan_nxt;
         amod_r   <= amod_nxt;
         apwr_r   <= apwr_nxt;
         fact_r   <= fact_nxt;
         txb_r    <= txb_nxt;
         exp_r    <= exp_nxt;
         done_r   <= done_nxt;
         div_r    <= div_nxt;
         nbit_r   <= nbit_nxt;
         err_r    <= err_nxt;
         sub_r    <= sub_nxt;
         pct_r    <= pct_nxt;
      end
   end
   assign o_factory_rst = fact_r;
   assign o_tx_en  = (st_r == ST_TXD);
   assign o_tx_bit = txb_r;
   assign o_rx_en  = (st_r == ST_RXW) || (st_r == ST_RXC);
   assign o_chan   = achan_r;
   assign o_mod    = amod_r;
   assign o_pwr    = apwr_r;

   // Read mux; unmapped addresses read zero with an error response
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_ok  = 1'b1;
      case ({i_s_axi_araddr[7:2], 2'b00})
         REG_CHAN:  rd_mux[7:0] = chan_r;
         REG_XMODE: rd_mux[3:0] = xm_r;
         REG_DIAG:  rd_mux[2:0] = st_r;
         REG_BERR:  rd_mux[9:0] = err_r;
         REG_BPCT:  rd_mux = {23'h00_0000, done_r, 1'b0, pct_r};
         REG_STAT:  rd_mux[1:0] = {fact_r, cmd_mode_r};
         default:   rd_ok = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_cmd_no_radio: assert property (o_radio_valid |-> $past(!cmd_mode_r))
      else $error("byte forwarded to radio in command mode");
   a_cmd_enter: assert property (!cmd_sync && !i_rx_busy && !i_rx_valid |=> cmd_mode_r)
      else $error("command mode not entered");
   a_mode_boundary: assert property ($changed(cmd_mode_r) |-> $past(!i_rx_busy && !i_rx_valid))
      else $error("mode changed inside a byte");
   a_factory_load: assert property (st_r == ST_INIT && settle_r == PWR_SETTLE && !cmd_sync
      |=> o_factory_rst && chan_r == FACT_CHAN && xm_r == FACT_XMODE)
      else $error("factory restore missing");
   a_nv_load: assert property (st_r == ST_INIT && settle_r == PWR_SETTLE && cmd_sync
      |=> !o_factory_rst && chan_r == $past(i_nv_cfg[7:0]))
      else $error("defaults not loaded");
   a_mode_at_start: assert property ($changed(o_mod) |-> $past(tx_go || rx_go))
      else $error("mode applied without a start");
   a_rx_power_kept: assert property (rx_go |=> $stable(o_pwr) ##1 o_rx_en)
      else $error("power changed by receive start");
   a_tx_alternate: assert property (o_tx_en && tick && !tx_go
      |=> o_tx_bit != $past(o_tx_bit) ##1 $stable(o_tx_bit))
      else $error("transmit pattern not alternating");
   a_rx_enter: assert property (rx_go |=> st_r == ST_RXW && o_rx_en && err_r == 10'h000)
      else $error("receive test not entered");
   a_ber_finish: assert property (st_r == ST_RXC && i_rf_bit_vld && nbit_r == BER_LAST
      |=> st_r == ST_RXDONE && done_r)
      else $error("error test did not finish");
   a_rx_wait_hold: assert property (st_r == ST_RXW && !(i_rf_bit_vld && i_rf_bit)
      |=> st_r == ST_RXW)
      else $error("receive wait left without data");
endmodule // rcmbd_top
`default_nettype wire

// [test/rcmbd_host_model.sv]
`default_nettype none
module rcmbd_host_model import rcmbd_pkg::*; (
   // Clock
   input  wire logic i_clk,
   // UART byte stream into the block
   output logic       o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic       o_rx_busy,
   // Bits from the remote transmitter
   output logic       o_rf_vld,
   output logic       o_rf_bit
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet lines at time zero
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data  = 8'h00;
      o_rx_busy  = 1'b0;
      o_rf_vld   = 1'b0;
      o_rf_bit   = 1'b0;
   end

   // Host never echoes traffic back, so no loopback rate cap is exceeded
   // Host never picks a fast data rate, so low power mode stays legal
   // Busy covers the whole frame, so a path switch must wait for the byte end
   task automatic send_byte(input logic [7:0] d, input int busy_cyc);
      o_rx_busy <= 1'b1;
      repeat (busy_cyc) @(posedge i_clk);
      o_rx_busy  <= 1'b0;
      o_rx_valid <= 1'b1;
      o_rx_data  <= d;
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      o_rx_data  <= ~d;  // Stale data inverted, never left looking valid
      @(posedge i_clk);
   endtask

   // Lead-in zero, sync one, then the alternating run with n_err flipped bits
   task automatic send_bits(input int n_err);
      logic b;
      for (int i = -2; i < BER_LEN; i++) begin
         b = (i < 0) ? (i == -1) : i[0];
         if (i >= 0 && i < n_err) b = ~b;
         o_rf_vld <= 1'b1;
         o_rf_bit <= b;
         @(posedge i_clk);
         o_rf_vld <= 1'b0;
         o_rf_bit <= ~b;
         @(posedge i_clk);
      end
   endtask
endmodule // rcmbd_host_model
`default_nettype wire

// [test/tb_radio_cmd_mode_and_ber_diag.sv]
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_radio_cmd_mode_and_ber_diag import rcmbd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // --------------------
   // Signals
   // --------------------
   localparam logic [11:0] NV = 12'ha5c;
   localparam int          NE = 37;
   logic        i_clk, i_rst_n = 1'b0, i_cmd_n = 1'b1;
   logic        rx_valid, rx_busy, rf_vld, rf_bit, cmd_valid, radio_valid;
   logic        factory_rst, tx_en, tx_bit, rx_en;
   logic [7:0]  rx_data, cmd_data, radio_data, chan, awaddr = 8'h00, araddr = 8'h00;
   logic [1:0]  mod, pwr, bresp, rresp, rs;
   logic [31:0] wdata = 32'h0000_0000, rdata, rd;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   int          n_mismatch = 0, checked = 0, cyc = 0;

   rcmbd_host_model p (.i_clk(i_clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
      .o_rx_busy(rx_busy), .o_rf_vld(rf_vld), .o_rf_bit(rf_bit));

   rcmbd_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_n(i_cmd_n),
      .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_busy(rx_busy),
      .o_cmd_valid(cmd_valid), .o_cmd_data(cmd_data), .o_radio_valid(radio_valid),
      .o_radio_data(radio_data), .i_nv_cfg(NV), .o_factory_rst(factory_rst), .o_tx_en(tx_en),
      .o_tx_bit(tx_bit), .o_rx_en(rx_en), .o_chan(chan), .o_mod(mod), .o_pwr(pwr),
      .i_rf_bit_vld(rf_vld), .i_rf_bit(rf_bit), .i_s_axi_awaddr(awaddr),
      .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
      .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready));

   // Clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // Hang guard: the whole run needs well under this many cycles
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         n_mismatch++;
         conclude();
      end
   end

   // --------------------
   // Bus and reset tasks
   // --------------------
   // Address and data are released independently, each when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge i_clk);
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end while (bvalid !== 1'b1);
      `CHK("bresp", RESP_OKAY, bresp)
      bready <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic axr(input logic [7:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge i_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge i_clk);
   endtask

   // Select held for the whole reset, well past the synchroniser depth
   task automatic rst(input logic c);
      int n;
      n = 0;
      i_cmd_n <= c;
      i_rst_n <= 1'b0;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (10) begin
         @(posedge i_clk);
         if (factory_rst === 1'b1) n++;
      end
      `CHK("factory pulses", c ? 0 : 1, n)
      axr(REG_CHAN);
      `CHK("chan", c ? NV[7:0] : FACT_CHAN, rd[7:0])
      axr(REG_XMODE);
      `CHK("xmode", c ? NV[11:8] : FACT_XMODE, rd[3:0])
   endtask

   task automatic wait_toggle(output int n);
      logic b;
      b = tx_bit;
      n = 0;
      while (tx_bit === b && n < 120) begin
         @(posedge i_clk);
         n++;
      end
   endtask

   // --------------------
   // Scenarios
   // --------------------
   task automatic t_route();
      i_cmd_n <= 1'b0;
      repeat (8) @(posedge i_clk);
      p.send_byte(8'h5a, 3);
      `CHK("cmd_valid", 1'b1, cmd_valid)
      `CHK("radio_valid", 1'b0, radio_valid)
      `CHK("cmd_data", 8'h5a, cmd_data)
      i_cmd_n <= 1'b1;
      p.send_byte(8'ha5, 6);
      `CHK("mid-byte switch", 1'b1, cmd_valid)
      repeat (6) @(posedge i_clk);
      p.send_byte(8'h3c, 1);
      `CHK("radio_valid", 1'b1, radio_valid)
      `CHK("radio_data", 8'h3c, radio_data)
      `CHK("cmd_valid", 1'b0, cmd_valid)
      axr(8'h20);
      `CHK("unmapped resp", RESP_SLV, rs)
      `CHK("unmapped data", 32'h0000_0000, rd)
   endtask

   // Error count is exact, so a single miscounted bit shows
   task automatic t_rx();
      logic [1:0] pw;
      axw(REG_CHAN, 32'h0000_0021);
      axw(REG_XMODE, 32'h0000_0006);
      pw = pwr;
      axw(REG_DIAG, 32'h0000_0002);
      `CHK("rx chan", 8'h21, chan)
      `CHK("rx mod", 2'h2, mod)
      `CHK("rx pwr", pw, pwr)
      `CHK("rx_en", 1'b1, rx_en)
      axw(REG_DIAG, 32'h0000_0001);
      `CHK("tx while waiting", 1'b0, tx_en)
      axr(REG_DIAG);
      `CHK("wait state", 3'h3, rd[2:0])
      p.send_bits(NE);
      repeat (3) @(posedge i_clk);
      axr(REG_BERR);
      `CHK("error count", 32'(NE), rd)
      axr(REG_BPCT);
      `CHK("percent", 32'((NE / BER_PCT_STEP) | (1 << BPCT_DONE)), rd)
   endtask

   task automatic t_tx();
      int n;
      axw(REG_CHAN, 32'h0000_0044);
      axw(REG_XMODE, 32'h0000_000d);
      `CHK("staged chan", 8'h21, chan)
      axw(REG_DIAG, 32'h0000_0001);
      `CHK("tx chan", 8'h44, chan)
      `CHK("tx mod", 2'h1, mod)
      `CHK("tx pwr", 2'h3, pwr)
      `CHK("tx_en", 1'b1, tx_en)
      wait_toggle(n);
      wait_toggle(n);
      `CHK("bit period", BIT_DIV, n)
      wait_toggle(n);
      `CHK("bit period", BIT_DIV, n)
      axw(REG_DIAG, 32'h0000_0004);
      `CHK("tx stopped", 1'b0, tx_en)
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Main sequence; the last reset shows the volatile writes are gone
   initial begin
      @(posedge i_clk);
      rst(1'b1);
      t_route();
      t_rx();
      t_tx();
      rst(1'b0);
      rst(1'b1);
      conclude();
   end
endmodule // tb_radio_cmd_mode_and_ber_diag
`default_nettype wire
